//--- hw/vhm_mac.sv
`timescale 1ns/100ps
// Summary of operation
// - Even unsigned sat multiply-subtract writes acc word minus lane product to target and acc.
// - A lane borrow there sets its excess flag and its sticky flag.
// - Guarded fractional forms take the low odd half-words (48:63) as signed fractions.
// - Guarded signed integer forms multiply those half-words as signed into 32 bits.
// - Guarded unsigned forms multiply those half-words as unsigned into 32 bits.
// - Guarded signed add adds the sign-extended product to the 64-bit acc.
// - Guarded signed subtract takes the sign-extended product from the acc.
// - Guarded unsigned add adds the zero-extended product to the acc.
// - Guarded unsigned subtract takes the zero-extended product from the acc.
// - Guarded sums wrap modulo 2^64 and leave the excess flags alone.
// - Odd fractional multiply puts the 16:31 product high and the 48:63 one low.
// - With accumulate-select set that result is also copied to the acc, else acc stays.
// - Odd fractional multiply-add adds each 32-bit product to its acc word.
// - Even elements are bits 0:15 for the high lane and 32:47 for the low.
// - Saturating forms write each lane flag and OR it into its sticky flag.
module vhm_mac
    import vhm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Instruction issue from the pipeline
    input wire logic issue_valid,
    input wire vhm_issue_t issue,
    // Result back to the register file
    output logic result_valid,
    output logic [63:0] result_data,
    output logic [63:0] running_sum_register,
    output vhm_flags_t vector_status_control_reg,
    // AXI4-Lite slave
    input wire logic [VHM_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [VHM_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Arithmetic helpers
    // Doubled signed product; -1 x -1 wraps
    function automatic logic [31:0] frac_mul(input logic [15:0] a, input logic [15:0] b);
        logic signed [31:0] p;
        p = $signed(a) * $signed(b);
        return {p[30:0], 1'b0};
    endfunction
    function automatic logic [31:0] sint_mul(input logic [15:0] a, input logic [15:0] b);
        return $signed(a) * $signed(b);
    endfunction
    function automatic logic [31:0] uint_mul(input logic [15:0] a, input logic [15:0] b);
        return a * b;
    endfunction
    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Operand lanes, big-endian bit numbering: element 0 is the top half-word
    logic [15:0] a_even_hi, a_even_lo, a_odd_hi, a_odd_lo;
    logic [15:0] b_even_hi, b_even_lo, b_odd_hi, b_odd_lo;

    assign a_even_hi = issue.source_one_gpr[63:48];
    assign a_odd_hi = issue.source_one_gpr[47:32];
    assign a_even_lo = issue.source_one_gpr[31:16];
    assign a_odd_lo = issue.source_one_gpr[15:0];
    assign b_even_hi = issue.source_two_gpr[63:48];
    assign b_odd_hi = issue.source_two_gpr[47:32];
    assign b_even_lo = issue.source_two_gpr[31:16];
    assign b_odd_lo = issue.source_two_gpr[15:0];

    ////////////////////////////////////////////////////////////////////////////////
    // State
    logic [63:0] acc_reg, acc_next;
    logic [63:0] result_reg, result_next;
    logic result_valid_reg, result_valid_next;
    vhm_flags_t flags_reg, flags_next;
    logic [VHM_IRQ_W-1:0] irq_status_reg, irq_status_next;
    logic [VHM_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
    logic [31:0] count_reg, count_next;

    logic aw_have_reg, aw_have_next;
    logic w_have_reg, w_have_next;
    logic [VHM_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Datapath result for the issued instruction
    logic [63:0] dp_result;
    logic dp_acc_wr, dp_sat, dp_ovh, dp_ovl;

    always_comb begin
        logic [32:0] diff_h, diff_l;
        logic [31:0] prod;
        logic [63:0] ext;
        diff_h = '0;
        diff_l = '0;
        prod = '0;
        ext = '0;
        dp_result = '0;
        dp_acc_wr = 1'b1;
        dp_sat = 1'b0;
        dp_ovh = 1'b0;
        dp_ovl = 1'b0;
        unique case (issue.op)
            VHM_OP_EU_SAT_SUB: begin
                // Extra top bit holds the borrow
                diff_h = {1'b0, acc_reg[63:32]} - {1'b0, uint_mul(a_even_hi, b_even_hi)};
                diff_l = {1'b0, acc_reg[31:0]} - {1'b0, uint_mul(a_even_lo, b_even_lo)};
                dp_sat = 1'b1;
                dp_ovh = diff_h[32];
                dp_ovl = diff_l[32];
                dp_result[63:32] = dp_ovh ? 32'h0000_0000 : diff_h[31:0];
                dp_result[31:0] = dp_ovl ? 32'h0000_0000 : diff_l[31:0];
            end
            VHM_OP_GSF_ADD, VHM_OP_GSF_SUB: begin
                prod = frac_mul(a_odd_lo, b_odd_lo);
                ext = {{32{prod[31]}}, prod};
                // Modulo 64-bit arithmetic, no flag update
                dp_result = (issue.op == VHM_OP_GSF_ADD) ? acc_reg + ext
                                                         : acc_reg - ext;
            end
            VHM_OP_GSI_ADD, VHM_OP_GSI_SUB: begin
                prod = sint_mul(a_odd_lo, b_odd_lo);
                ext = {{32{prod[31]}}, prod};
                dp_result = (issue.op == VHM_OP_GSI_ADD) ? acc_reg + ext
                                                         : acc_reg - ext;
            end
            VHM_OP_GUI_ADD, VHM_OP_GUI_SUB: begin
                prod = uint_mul(a_odd_lo, b_odd_lo);
                ext = {32'h0000_0000, prod};
                dp_result = (issue.op == VHM_OP_GUI_ADD) ? acc_reg + ext
                                                         : acc_reg - ext;
            end
            VHM_OP_OSF_MUL: begin
                dp_result = {frac_mul(a_odd_hi, b_odd_hi), frac_mul(a_odd_lo, b_odd_lo)};
                dp_acc_wr = issue.acc_sel;
            end
            VHM_OP_OSF_ADDW: begin
                dp_result[63:32] = acc_reg[63:32] + frac_mul(a_odd_hi, b_odd_hi);
                dp_result[31:0] = acc_reg[31:0] + frac_mul(a_odd_lo, b_odd_lo);
            end
            default: dp_acc_wr = 1'b0; // Undefined code leaves the accumulator alone
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshakes
    logic wr_fire, rd_fire;

    assign s_axi_awready = !aw_have_reg && !bvalid_reg;
    assign s_axi_wready = !w_have_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state: register file, datapath commit, bus
    always_comb begin
        acc_next = acc_reg;
        result_next = result_reg;
        result_valid_next = issue_valid;
        flags_next = flags_reg;
        irq_status_next = irq_status_reg;
        irq_mask_next = irq_mask_reg;
        count_next = count_reg;
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;

        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end

        // Software write first; hardware updates below take precedence
        if (wr_fire) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = VHM_RESP_OKAY;
            unique case (aw_addr_reg)
                VHM_OFS_STATUS:
                    flags_next = VHM_FLAGS_W'(strb_merge({28'h000_0000, flags_reg}, w_data_reg,
                                                         w_strb_reg));
                VHM_OFS_ACC_HI:
                    acc_next[63:32] = strb_merge(acc_reg[63:32], w_data_reg, w_strb_reg);
                VHM_OFS_ACC_LO:
                    acc_next[31:0] = strb_merge(acc_reg[31:0], w_data_reg, w_strb_reg);
                VHM_OFS_IRQ_STATUS:
                    irq_status_next = irq_status_reg
                        & ~(w_data_reg[VHM_IRQ_W-1:0] & {VHM_IRQ_W{w_strb_reg[0]}});
                VHM_OFS_IRQ_MASK:
                    irq_mask_next = VHM_IRQ_W'(strb_merge({29'h0000_0000, irq_mask_reg},
                                                          w_data_reg, w_strb_reg));
                VHM_OFS_OP_COUNT: ; // Read-only: the write is dropped but answered OKAY
                default: bresp_next = VHM_RESP_SLVERR;
            endcase
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end

        if (rd_fire) begin
            rvalid_next = 1'b1;
            rresp_next = VHM_RESP_OKAY;
            unique case (s_axi_araddr)
                VHM_OFS_STATUS: rdata_next = {28'h000_0000, flags_reg};
                VHM_OFS_ACC_HI: rdata_next = acc_reg[63:32];
                VHM_OFS_ACC_LO: rdata_next = acc_reg[31:0];
                VHM_OFS_IRQ_STATUS: rdata_next = {29'h0000_0000, irq_status_reg};
                VHM_OFS_IRQ_MASK: rdata_next = {29'h0000_0000, irq_mask_reg};
                VHM_OFS_OP_COUNT: rdata_next = count_reg;
                default: begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = VHM_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end

        // Instruction commit wins over a same-cycle software write
        if (issue_valid) begin
            result_next = dp_result;
            count_next = count_reg + 32'h0000_0001;
            irq_status_next[VHM_IRQ_DONE] = 1'b1;
            if (dp_acc_wr) begin
                acc_next = dp_result;
            end
            if (dp_sat) begin
                flags_next.high_lane_excess_flag = dp_ovh;
                flags_next.low_lane_excess_flag = dp_ovl;
                flags_next.high_lane_sticky_excess |= dp_ovh;
                flags_next.low_lane_sticky_excess |= dp_ovl;
                irq_status_next[VHM_IRQ_HIGH_UNDER] |= dp_ovh;
                irq_status_next[VHM_IRQ_LOW_UNDER] |= dp_ovl;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_reg <= VHM_ACC_RESET;
            result_reg <= VHM_ACC_RESET;
            result_valid_reg <= 1'b0;
            flags_reg <= VHM_FLAGS_RESET;
            irq_status_reg <= VHM_IRQ_RESET;
            irq_mask_reg <= VHM_IRQ_RESET;
            count_reg <= VHM_COUNT_RESET;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= VHM_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= VHM_RESP_OKAY;
        end else begin
            acc_reg <= acc_next;
            result_reg <= result_next;
            result_valid_reg <= result_valid_next;
            flags_reg <= flags_next;
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
            count_reg <= count_next;
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign result_valid = result_valid_reg;
    assign result_data = result_reg;
    assign running_sum_register = acc_reg;
    assign vector_status_control_reg = flags_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign irq = |(irq_status_reg & irq_mask_reg);

endmodule

//--- inc/vhm_pkg.sv
package vhm_pkg;

    // Instruction group handled by the datapath
    typedef enum logic [3:0] {
        VHM_OP_EU_SAT_SUB = 4'b0000,
        VHM_OP_GSF_ADD    = 4'b0001,
        VHM_OP_GSF_SUB    = 4'b0010,
        VHM_OP_GSI_ADD    = 4'b0011,
        VHM_OP_GSI_SUB    = 4'b0100,
        VHM_OP_GUI_ADD    = 4'b0101,
        VHM_OP_GUI_SUB    = 4'b0110,
        VHM_OP_OSF_MUL    = 4'b0111,
        VHM_OP_OSF_ADDW   = 4'b1000
    } vhm_op_t;

    typedef struct packed {
        vhm_op_t op;
        logic acc_sel;
        logic [63:0] source_one_gpr;
        logic [63:0] source_two_gpr;
    } vhm_issue_t;

    // Vector status flags, low excess in bit 0
    typedef struct packed {
        logic high_lane_sticky_excess;
        logic low_lane_sticky_excess;
        logic high_lane_excess_flag;
        logic low_lane_excess_flag;
    } vhm_flags_t;

    localparam int VHM_ADDR_W = 8;
    localparam int VHM_FLAGS_W = 4;
    localparam int VHM_IRQ_W = 3;

    // Register byte offsets
    localparam logic [VHM_ADDR_W-1:0] VHM_OFS_STATUS = 8'h00;
    localparam logic [VHM_ADDR_W-1:0] VHM_OFS_ACC_HI = 8'h04;
    localparam logic [VHM_ADDR_W-1:0] VHM_OFS_ACC_LO = 8'h08;
    localparam logic [VHM_ADDR_W-1:0] VHM_OFS_IRQ_STATUS = 8'h0C;
    localparam logic [VHM_ADDR_W-1:0] VHM_OFS_IRQ_MASK = 8'h10;
    localparam logic [VHM_ADDR_W-1:0] VHM_OFS_OP_COUNT = 8'h14;

    // Interrupt event bit positions
    localparam int VHM_IRQ_LOW_UNDER = 0;
    localparam int VHM_IRQ_HIGH_UNDER = 1;
    localparam int VHM_IRQ_DONE = 2;

    // Reset values
    localparam logic [63:0] VHM_ACC_RESET = 64'h0000_0000_0000_0000;
    localparam logic [VHM_FLAGS_W-1:0] VHM_FLAGS_RESET = 4'h0;
    localparam logic [VHM_IRQ_W-1:0] VHM_IRQ_RESET = 3'h0;
    localparam logic [31:0] VHM_COUNT_RESET = 32'h0000_0000;

    // AXI responses
    localparam logic [1:0] VHM_RESP_OKAY = 2'b00;
    localparam logic [1:0] VHM_RESP_SLVERR = 2'b10;

endpackage

//--- verif/vhm_mac_properties.sv
`timescale 1ns/100ps
module vhm_mac_properties
    import vhm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Instruction side
    input wire logic issue_valid,
    input wire vhm_issue_t issue,
    input wire logic result_valid,
    input wire logic [63:0] result_data,
    input wire logic [63:0] running_sum_register,
    input wire vhm_flags_t vector_status_control_reg,
    // Masks checks that a software write may race
    input wire logic s_axi_awvalid
);
    logic [63:0] s1;
    logic [63:0] s2;
    logic [63:0] acc;
    logic signed [31:0] prod_si;
    logic [31:0] prod_ui;
    logic [31:0] prod_hi;
    logic [31:0] prod_lo;
    logic under_hi;
    logic under_lo;
    vhm_flags_t fl;
    assign s1 = issue.source_one_gpr;
    assign s2 = issue.source_two_gpr;
    assign acc = running_sum_register;
    assign fl = vector_status_control_reg;
    assign prod_si = $signed(s1[15:0]) * $signed(s2[15:0]);
    assign prod_ui = s1[15:0] * s2[15:0];
    assign prod_hi = s1[63:48] * s2[63:48];
    assign prod_lo = s1[31:16] * s2[31:16];
    assign under_hi = prod_hi > acc[63:32];
    assign under_lo = prod_lo > acc[31:0];
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_sat;
        issue_valid && issue.op == VHM_OP_EU_SAT_SUB;
    endsequence
    sequence s_guarded;
        issue_valid && issue.op >= VHM_OP_GSF_ADD && issue.op <= VHM_OP_GUI_SUB;
    endsequence
    sequence s_osf;
        issue_valid && issue.op == VHM_OP_OSF_MUL;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_result_latency: assert property (issue_valid |=> result_valid)
        else $error("late result");
    a_no_stray: assert property (!issue_valid |=> !result_valid)
        else $error("result without issue");
    a_sat_high_value: assert property (
        s_sat ##0 !under_hi |=> result_data[63:32] == $past(acc[63:32] - prod_hi))
        else $error("high difference");
    a_sat_to_acc: assert property (s_sat |=> running_sum_register == result_data)
        else $error("sat acc copy");
    a_low_clamp: assert property (
        s_sat ##0 under_lo |=> result_data[31:0] == 32'h0000_0000
        && fl.low_lane_excess_flag && fl.low_lane_sticky_excess)
        else $error("low underflow");
    a_high_clamp: assert property (
        s_sat ##0 under_hi |=> result_data[63:32] == 32'h0000_0000
        && fl.high_lane_excess_flag && fl.high_lane_sticky_excess)
        else $error("high underflow");
    a_no_false_flag: assert property (
        s_sat ##0 !under_lo |=> !fl.low_lane_excess_flag)
        else $error("stray low flag");
    a_signed_add: assert property (
        issue_valid && issue.op == VHM_OP_GSI_ADD
        |=> acc == $past(acc + {{32{prod_si[31]}}, prod_si}))
        else $error("signed sum");
    a_unsigned_sub: assert property (
        issue_valid && issue.op == VHM_OP_GUI_SUB
        |=> acc == $past(acc - {32'h0000_0000, prod_ui}))
        else $error("unsigned difference");
    a_guarded_dest: assert property (s_guarded |=> result_data == acc)
        else $error("guarded acc copy");
    a_guarded_flags: assert property (
        s_guarded ##0 !s_axi_awvalid |=> fl == $past(fl))
        else $error("guarded flags");
    a_acc_hold: assert property (
        s_osf ##0 !issue.acc_sel && !s_axi_awvalid |=> acc == $past(acc))
        else $error("acc not held");
    a_acc_copy: assert property (s_osf ##0 issue.acc_sel |=> acc == result_data)
        else $error("acc not copied");
endmodule

bind vhm_mac vhm_mac_properties u_props (
    .aclk(aclk),
    .aresetn(aresetn),
    .issue_valid(issue_valid),
    .issue(issue),
    .result_valid(result_valid),
    .result_data(result_data),
    .running_sum_register(running_sum_register),
    .vector_status_control_reg(vector_status_control_reg),
    .s_axi_awvalid(s_axi_awvalid)
);

//--- verif/vhm_pipe_model.sv
`timescale 1ns/100ps
module vhm_pipe_model
    import vhm_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Issue to the datapath
    output logic issue_valid,
    output vhm_issue_t issue,
    // Write-back from the datapath
    input wire logic result_valid,
    input wire logic [63:0] result_data
);
    logic [63:0] dest_gpr;
    initial begin
        issue_valid = 1'b0;
        issue = '0;
    end
    always @(posedge aclk) begin
        if (result_valid) dest_gpr <= result_data;
    end
    task automatic send(input vhm_op_t op, input logic sel, input logic [63:0] a,
                        input logic [63:0] b);
        @(posedge aclk);
        issue_valid <= 1'b1;
        issue <= '{op: op, acc_sel: sel, source_one_gpr: a, source_two_gpr: b};
    endtask
    // Idle operands are scrambled so a stale value can never pass for a live one
    task automatic idle();
        @(posedge aclk);
        issue_valid <= 1'b0;
        issue <= ~issue;
    endtask
endmodule

//--- verif/tb.sv
`timescale 1ns/100ps
module tb
    import vhm_pkg::*;
;
    typedef struct {
        vhm_op_t op;
        logic sel;
        logic [3:0] fin;
        logic [63:0] acc, s1, s2, res, acc_o;
        logic [3:0] fout;
    } vhm_row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic issue_valid, result_valid, irq;
    vhm_issue_t issue;
    logic [63:0] result_data, running_sum_register;
    vhm_flags_t vector_status_control_reg;
    logic [VHM_ADDR_W-1:0] s_axi_awaddr = '0;
    logic [VHM_ADDR_W-1:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] rd;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [VHM_ADDR_W-1:0] regs [6] = '{VHM_OFS_STATUS, VHM_OFS_ACC_HI, VHM_OFS_ACC_LO,
        VHM_OFS_IRQ_STATUS, VHM_OFS_IRQ_MASK, VHM_OFS_OP_COUNT};
    vhm_row_t rows [11] = '{
        '{VHM_OP_EU_SAT_SUB, 1'b0, 4'h8, 64'h0000_0010_0000_0100, 64'h0003_0000_0010_0000,
          64'h0004_0000_0020_0000, 64'h0000_0004_0000_0000, 64'h0000_0004_0000_0000, 4'hD},
        '{VHM_OP_EU_SAT_SUB, 1'b0, 4'h0, 64'h0000_0000_FFFE_0001, 64'hFFFF_0000_FFFF_0000,
          64'h0001_0000_FFFF_0000, 64'h0, 64'h0, 4'hA},
        '{VHM_OP_GSF_ADD, 1'b0, 4'hF, 64'h1, 64'h7FFF_1234_5678_4000,
          64'h1111_2222_3333_4000, 64'h2000_0001, 64'h2000_0001, 4'hF},
        '{VHM_OP_GSF_SUB, 1'b0, 4'hF, 64'h0, 64'h8000, 64'h8000, 64'h8000_0000,
          64'h8000_0000, 4'hF},
        '{VHM_OP_GSI_ADD, 1'b0, 4'hF, 64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_0002,
          64'h8000_8000_8000_0003, 64'h5, 64'h5, 4'hF},
        '{VHM_OP_GSI_SUB, 1'b0, 4'hF, 64'h0, 64'hFFFF, 64'h5, 64'h5, 64'h5, 4'hF},
        '{VHM_OP_GUI_ADD, 1'b0, 4'hF, 64'h0000_0001_0000_0000, 64'hFFFF, 64'hFFFF,
          64'h0000_0001_FFFE_0001, 64'h0000_0001_FFFE_0001, 4'hF},
        '{VHM_OP_GUI_SUB, 1'b0, 4'hF, 64'h0, 64'hFFFF, 64'hFFFF, 64'hFFFF_FFFF_0001_FFFF,
          64'hFFFF_FFFF_0001_FFFF, 4'hF},
        '{VHM_OP_OSF_MUL, 1'b0, 4'h3, 64'h1234_5678_9ABC_DEF0, 64'h4000_0000_2000,
          64'h4000_0000_C000, 64'h2000_0000_F000_0000, 64'h1234_5678_9ABC_DEF0, 4'h3},
        '{VHM_OP_OSF_MUL, 1'b1, 4'h3, 64'h1234_5678_9ABC_DEF0, 64'h4000_0000_2000,
          64'h4000_0000_C000, 64'h2000_0000_F000_0000, 64'h2000_0000_F000_0000, 4'h3},
        '{VHM_OP_OSF_ADDW, 1'b0, 4'h3, 64'h7FFF_FFFF_0000_0010, 64'h4000_0000_8000,
          64'h4000_0000_8000, 64'h9FFF_FFFF_8000_0010, 64'h9FFF_FFFF_8000_0010, 4'h3}};
    always #5 aclk = ~aclk;
    vhm_mac u_dut (.aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid), .issue(issue),
        .result_valid(result_valid), .result_data(result_data),
        .running_sum_register(running_sum_register),
        .vector_status_control_reg(vector_status_control_reg),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .irq(irq));
    vhm_pipe_model u_pipe (.aclk(aclk), .issue_valid(issue_valid), .issue(issue),
        .result_valid(result_valid), .result_data(result_data));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic axi_wr(input logic [VHM_ADDR_W-1:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [VHM_ADDR_W-1:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (regs[i]) begin
            axi_rd(regs[i], rd, rsp);
            chk("reset value", 64'h0, 64'(rd));
        end
        foreach (rows[i]) begin
            vhm_row_t r;
            r = rows[i];
            axi_wr(VHM_OFS_ACC_HI, r.acc[63:32], rsp);
            axi_wr(VHM_OFS_ACC_LO, r.acc[31:0], rsp);
            axi_wr(VHM_OFS_STATUS, 32'(r.fin), rsp);
            u_pipe.send(r.op, r.sel, r.s1, r.s2);
            u_pipe.idle();
            @(negedge aclk);
            chk("valid", 64'h1, 64'(result_valid));
            chk("res", r.res, result_data);
            chk("acc", r.acc_o, running_sum_register);
            chk("flags", 64'(r.fout), 64'(vector_status_control_reg));
        end
        axi_wr(VHM_OFS_ACC_HI, 32'h0000_0000, rsp);
        axi_wr(VHM_OFS_ACC_LO, 32'h0000_0000, rsp);
        u_pipe.send(VHM_OP_GSI_ADD, 1'b0, 64'h2, 64'h3);
        u_pipe.send(VHM_OP_GSI_SUB, 1'b0, 64'hFFFF, 64'h1);
        @(negedge aclk);
        chk("first of pair", 64'h6, result_data);
        u_pipe.idle();
        @(negedge aclk);
        chk("second of pair", 64'h7, running_sum_register);
        axi_rd(8'h40, rd, rsp);
        chk("unmapped rresp", 64'(VHM_RESP_SLVERR), 64'(rsp));
        axi_wr(8'h40, 32'hFFFF_FFFF, rsp);
        chk("unmapped bresp", 64'(VHM_RESP_SLVERR), 64'(rsp));
        axi_wr(VHM_OFS_OP_COUNT, 32'h0000_0000, rsp);
        axi_rd(VHM_OFS_OP_COUNT, rd, rsp);
        chk("count", 64'hD, 64'(rd));
        @(negedge aclk);
        chk("irq masked", 64'h0, 64'(irq));
        axi_wr(VHM_OFS_IRQ_MASK, 32'h0000_0004, rsp);
        @(negedge aclk);
        chk("irq done", 64'h1, 64'(irq));
        axi_wr(VHM_OFS_IRQ_STATUS, 32'h0000_0004, rsp);
        axi_rd(VHM_OFS_IRQ_STATUS, rd, rsp);
        chk("irq status", 64'h3, 64'(rd));
        axi_wr(VHM_OFS_IRQ_MASK, 32'h0000_0003, rsp);
        @(negedge aclk);
        chk("irq underflow", 64'h1, 64'(irq));
        axi_wr(VHM_OFS_IRQ_STATUS, 32'h0000_0003, rsp);
        @(negedge aclk);
        chk("irq cleared", 64'h0, 64'(irq));
        @(posedge aclk);
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk("acc after reset", 64'h0, running_sum_register);
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge aclk);
        n_mismatch++;
        end_of_test();
    end
endmodule
